// ### inc/vcs_pkg.sv
package vcs_pkg;
  // Bus address byte including the write direction bit
  localparam logic [7:0] DEV_ADDR = 8'hec;
  localparam logic [7:0] ADDR_BYTE_RST = 8'h00;
  // Data byte field positions
  localparam int GAIN_MSB = 7;
  localparam int GAIN_LSB = 3;
  localparam int MUTE_POS = 2;
  localparam int LEFT_POS = 1;
  localparam int RIGHT_POS = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Serial clock limit and derived cycle counts at 20 MHz
  localparam int CLK_HZ = 20000000;
  localparam int SCL_MAX_HZ = 400000;
  localparam int HALF_CYC = CLK_HZ / SCL_MAX_HZ / 2;
  localparam int QTR_CYC = HALF_CYC / 2;
  typedef enum logic [2:0] {
    VCS_IDLE = 3'b000,
    VCS_ADDR = 3'b001,
    VCS_AACK = 3'b011,
    VCS_DATA = 3'b010,
    VCS_DACK = 3'b110,
    VCS_SKIP = 3'b111
  } vcs_state_t;
endpackage

// ### inc/vcs_if.sv
`timescale 1ns/1ns
interface vcs_if;
  logic scl;
  logic sda_m_oe;
  logic sda_s_oe;
  // Open-drain wire with pull-up: low whenever anyone drives
  logic sda;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport dev (input scl, input sda, output sda_s_oe);
  modport host (output scl, input sda, output sda_m_oe);
endinterface

// ### hdl/vcs_device.sv
`timescale 1ns/1ns
// Functional notes
// - Map 5-bit code to 32 gain steps
// - Host alone drives serial clock
// - Data line only pulled low or released
// - Serial clock at most 400kHz (bench runs both hosts with 8-cycle phases, 1.25MHz)
// - Start: data falls while clock high
// - Compare address byte with own address
// - Host sends 8-bit address, MSB first
// - Sample data on clock rising edge
// - Address bits steady while clock high
// - Host releases data for acknowledge clock
// - Matching address acknowledged low whole pulse
// - Host abandons on missing address acknowledge
// - Host sends 8 data bits MSB first
// - Each data byte acknowledged on ninth clock
// - Accept every further data byte
// - Stop: data rises while clock high
// - Host leaves data high when idle
// - Own address byte is 11101100
// - Byte holds gain, mute, left, right
module vcs_device (
  input wire logic clock,
  input wire logic nrst,
  vcs_if.dev bus,
  output logic [4:0] gain_code,
  output logic signed [7:0] gain_db,
  output logic mute,
  output logic left_channel_on,
  output logic right_channel_on,
  output logic left_active,
  output logic right_active,
  output logic byte_stb
);
  // Signed gain in dB for each code
  function automatic logic signed [7:0] gain_lut(input logic [4:0] c);
    unique case (c)
      5'h00: gain_lut = -8'sd76;
      5'h01: gain_lut = -8'sd62;
      5'h02: gain_lut = -8'sd52;
      5'h03: gain_lut = -8'sd44;
      5'h04: gain_lut = -8'sd38;
      5'h05: gain_lut = -8'sd34;
      5'h06: gain_lut = -8'sd30;
      5'h07: gain_lut = -8'sd27;
      5'h08: gain_lut = -8'sd24;
      5'h09: gain_lut = -8'sd21;
      5'h0a: gain_lut = -8'sd18;
      5'h0b: gain_lut = -8'sd16;
      5'h0c: gain_lut = -8'sd14;
      5'h0d: gain_lut = -8'sd12;
      5'h0e: gain_lut = -8'sd10;
      5'h0f: gain_lut = -8'sd8;
      5'h10: gain_lut = -8'sd6; // Printed as +6, sequence says -6
      5'h11: gain_lut = -8'sd4;
      5'h12: gain_lut = -8'sd2;
      5'h13: gain_lut = 8'sd0;
      5'h14: gain_lut = 8'sd2;
      5'h15: gain_lut = 8'sd4;
      5'h16: gain_lut = 8'sd6;
      5'h17: gain_lut = 8'sd8;
      5'h18: gain_lut = 8'sd10;
      5'h19: gain_lut = 8'sd12;
      5'h1a: gain_lut = 8'sd13;
      5'h1b: gain_lut = 8'sd14;
      5'h1c: gain_lut = 8'sd15;
      5'h1d: gain_lut = 8'sd16;
      5'h1e: gain_lut = 8'sd17;
      default: gain_lut = 8'sd18;
    endcase
  endfunction

  logic [1:0] scl_sy_r;
  logic [1:0] sda_sy_r;
  logic scl_d_r;
  logic sda_d_r;
  vcs_pkg::vcs_state_t st_r;
  vcs_pkg::vcs_state_t st_nxt;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [7:0] ctrl_r;
  logic ack_r;
  logic stb_r;
  logic signed [7:0] gain_r;
  logic l_act_r;
  logic r_act_r;

  // Only the second stage is looked at by any logic
  wire scl_s = scl_sy_r[1];
  wire sda_s = sda_sy_r[1];
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire [7:0] sh_new = {sh_r[6:0], sda_s};
  wire byte_done = scl_rise && (bit_cnt_r == 4'd7);
  wire addr_hit = (sh_new == vcs_pkg::DEV_ADDR);
  wire in_byte = (st_r == vcs_pkg::VCS_ADDR) ||
    (st_r == vcs_pkg::VCS_DATA);
  wire in_data = (st_r == vcs_pkg::VCS_DATA);
  wire in_ack = (st_r == vcs_pkg::VCS_AACK) ||
    (st_r == vcs_pkg::VCS_DACK);
  wire [4:0] code = ctrl_r[vcs_pkg::GAIN_MSB:vcs_pkg::GAIN_LSB];

  always_comb begin
    st_nxt = st_r;
    if (start_det) begin
      st_nxt = vcs_pkg::VCS_ADDR;
    end else if (stop_det) begin
      st_nxt = vcs_pkg::VCS_IDLE;
    end else begin
      unique case (st_r)
        vcs_pkg::VCS_IDLE: st_nxt = vcs_pkg::VCS_IDLE;
        vcs_pkg::VCS_ADDR: begin
          if (byte_done) begin
            st_nxt = addr_hit ? vcs_pkg::VCS_AACK : vcs_pkg::VCS_SKIP;
          end
        end
        vcs_pkg::VCS_AACK: begin
          if (scl_fall && bit_cnt_r == 4'd9) st_nxt = vcs_pkg::VCS_DATA;
        end
        vcs_pkg::VCS_DATA: begin
          if (byte_done) st_nxt = vcs_pkg::VCS_DACK;
        end
        vcs_pkg::VCS_DACK: begin
          if (scl_fall && bit_cnt_r == 4'd9) st_nxt = vcs_pkg::VCS_DATA;
        end
        vcs_pkg::VCS_SKIP: st_nxt = vcs_pkg::VCS_SKIP;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sy_r <= {scl_sy_r[0], bus.scl};
      sda_sy_r <= {sda_sy_r[0], bus.sda};
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_r <= vcs_pkg::VCS_IDLE;
      bit_cnt_r <= 4'h0;
      sh_r <= vcs_pkg::ADDR_BYTE_RST;
    end else begin
      st_r <= st_nxt;
      if (start_det || (scl_fall && bit_cnt_r == 4'd9)) begin
        bit_cnt_r <= 4'h0;
      end else if (in_byte && scl_rise) begin
        sh_r <= sh_new; // MSB first
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (scl_fall && bit_cnt_r == 4'd8) begin
        bit_cnt_r <= 4'd9; // Acknowledge window open
      end
    end
  end

  // Ack pulled low from the 8th falling edge to the 9th falling edge
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_r <= 1'b0;
    end else if (scl_fall && bit_cnt_r == 4'd8) begin
      ack_r <= in_ack;
    end else if (scl_fall && bit_cnt_r == 4'd9) begin
      ack_r <= 1'b0;
    end
  end
  // Only ever pull low or release
  assign bus.sda_s_oe = ack_r;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_r <= vcs_pkg::CTRL_RST;
      stb_r <= 1'b0;
    end else begin
      stb_r <= in_data && byte_done;
      if (in_data && byte_done) begin
        ctrl_r <= sh_new;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      gain_r <= -8'sd76;
      l_act_r <= 1'b0;
      r_act_r <= 1'b0;
    end else begin
      gain_r <= gain_lut(code);
      l_act_r <= ctrl_r[vcs_pkg::LEFT_POS] & ~ctrl_r[vcs_pkg::MUTE_POS];
      r_act_r <= ctrl_r[vcs_pkg::RIGHT_POS] & ~ctrl_r[vcs_pkg::MUTE_POS];
    end
  end

  assign gain_code = code;
  assign gain_db = gain_r;
  assign mute = ctrl_r[vcs_pkg::MUTE_POS];
  assign left_channel_on = ctrl_r[vcs_pkg::LEFT_POS];
  assign right_channel_on = ctrl_r[vcs_pkg::RIGHT_POS];
  assign left_active = l_act_r;
  assign right_active = r_act_r;
  assign byte_stb = stb_r;
endmodule

// ### hdl/vcs_host.sv
`timescale 1ns/1ns
module vcs_host #(
  parameter int HALF = vcs_pkg::HALF_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  vcs_if.host bus,
  input wire logic req,
  input wire logic [7:0] wdata,
  input wire logic last,
  output logic wready,
  output logic busy,
  output logic done,
  output logic nack
);
  // Below four cycles the mid-low data change collides with the edges
  if (HALF < 4) begin : g_half_chk
    $error("HALF too small");
  end
  localparam int Q = HALF / 2;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_START = 3'b001, H_BIT = 3'b011,
    H_ACK = 3'b010, H_STOP = 3'b110
  } vcs_hst_t;

  vcs_hst_t st_r;
  logic [15:0] tmr_r;
  logic ph_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic is_addr_r;
  logic scl_r;
  logic sda_oe_r;
  logic [1:0] sda_sy_r;
  logic wready_r;
  logic done_r;
  logic nack_r;
  logic last_r;
  wire tick = (tmr_r == 16'(HALF - 1));
  wire mid = (tmr_r == 16'(Q));

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sda_sy_r <= 2'h3;
    end else begin
      sda_sy_r <= {sda_sy_r[0], bus.sda};
    end
  end

  // Clock driven one way for HALF cycles; the default HALF keeps it <= 400kHz
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_r <= H_IDLE;
      tmr_r <= 16'h0;
      ph_r <= 1'b0;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      is_addr_r <= 1'b0;
      scl_r <= 1'b1;
      sda_oe_r <= 1'b0; // Line released when idle
      wready_r <= 1'b0;
      done_r <= 1'b0;
      nack_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      wready_r <= 1'b0;
      tmr_r <= tick ? 16'h0 : tmr_r + 16'h1;
      unique case (st_r)
        H_IDLE: begin
          tmr_r <= 16'h0;
          if (req) begin
            st_r <= H_START;
            sh_r <= vcs_pkg::DEV_ADDR;
            is_addr_r <= 1'b1;
            nack_r <= 1'b0;
            sda_oe_r <= 1'b1; // Start with clock high
          end
        end
        H_START: if (tick) begin
          scl_r <= 1'b0;
          st_r <= H_BIT;
          ph_r <= 1'b0;
          bit_r <= 3'h0;
        end
        H_BIT: begin
          // Data changes mid-low so it is steady while clock high
          if (!ph_r && mid) sda_oe_r <= ~sh_r[7];
          if (tick) begin
            ph_r <= ~ph_r;
            scl_r <= ~ph_r;
            if (ph_r) begin
              sh_r <= {sh_r[6:0], 1'b0};
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7) st_r <= H_ACK;
            end
          end
        end
        H_ACK: begin
          if (!ph_r && mid) sda_oe_r <= 1'b0; // Release for ack
          if (tick) begin
            ph_r <= ~ph_r;
            scl_r <= ~ph_r;
            if (ph_r) begin
              // Check ack at end of high phase
              if (sda_sy_r[1] || last_r) begin
                nack_r <= sda_sy_r[1];
                st_r <= H_STOP;
                ph_r <= 1'b0;
              end else begin
                sh_r <= wdata;
                last_r <= last;
                wready_r <= 1'b1;
                is_addr_r <= 1'b0;
                st_r <= H_BIT;
              end
            end
          end
        end
        H_STOP: begin
          if (!ph_r && mid) sda_oe_r <= 1'b1;
          if (tick) begin
            ph_r <= 1'b1;
            scl_r <= 1'b1;
            if (ph_r) begin
              sda_oe_r <= 1'b0; // Data rises, clock high
              st_r <= H_IDLE;
              done_r <= 1'b1;
              last_r <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  assign bus.scl = scl_r;
  assign bus.sda_m_oe = sda_oe_r;
  assign wready = wready_r;
  assign busy = (st_r != H_IDLE);
  assign done = done_r;
  assign nack = nack_r;
endmodule

// ### sim/vcs_monitor.sv
`timescale 1ns/1ns
module vcs_monitor #(
  parameter int HALF = vcs_pkg::HALF_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe
);
  localparam int HMIN = HALF / 2;
  logic scl_q, sda_q, first, sel;
  logic [3:0] bc;
  logic [7:0] sh, hc;
  wire rise = scl & ~scl_q;
  wire start = scl & scl_q & sda_q & ~sda;
  wire stop = scl & scl_q & ~sda_q & sda;
  wire own = sh == vcs_pkg::DEV_ADDR;
  wire ack_due = rise & (bc == 4'h8) & (first ? own : sel);
  always_ff @(posedge clock) begin
    scl_q <= scl;
    sda_q <= sda;
    hc <= (!nrst || scl != scl_q) ? 8'h00 : hc + {7'h00, hc != 8'hff};
  end
  // Bit count restarts at every start; ninth rise is the ack slot
  always_ff @(posedge clock) begin
    if (!nrst || start) begin
      bc <= 4'h0;
      first <= nrst;
      sh <= 8'h00;
    end else if (rise) begin
      sh <= {sh[6:0], sda};
      bc <= (bc == 4'h8) ? 4'h0 : bc + 4'h1;
      first <= first & (bc != 4'h8);
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sel <= 1'b0;
    end else if (rise && bc == 4'h8 && first) begin
      sel <= own;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_start; start |-> sda_m_oe ##[1:40] !scl; endproperty
  a_start: assert property (p_start)
    else $error("start not followed by clock low");
  property p_half; (scl != scl_q) |-> hc >= HMIN; endproperty
  a_half: assert property (p_half)
    else $error("serial clock phase too short");
  property p_soe_edge; $rose(sda_s_oe) |-> !scl; endproperty
  a_soe_edge: assert property (p_soe_edge)
    else $error("device pulled data while clock high");
  property p_soe_hold; sda_s_oe && scl |=> sda_s_oe || !scl; endproperty
  a_soe_hold: assert property (p_soe_hold)
    else $error("device ack dropped during clock high");
  property p_ack; ack_due |-> !sda && sda_s_oe; endproperty
  a_ack: assert property (p_ack)
    else $error("ack missing on ninth clock");
  property p_rel; rise && bc == 4'h8 |-> !sda_m_oe; endproperty
  a_rel: assert property (p_rel)
    else $error("host drove data in ack slot");
  property p_stop; stop |-> (!sda_s_oe)[*4]; endproperty
  a_stop: assert property (p_stop)
    else $error("device drove data after stop");
  property p_idle; stop |=> (scl && sda)[*3]; endproperty
  a_idle: assert property (p_idle)
    else $error("bus not idle high after stop");
endmodule

// ### sim/vcs_test.sv
`timescale 1ns/1ns
module vcs_test;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic req = 1'b0, req2 = 1'b0, last = 1'b0;
  logic bscl = 1'b1, bm = 1'b0, ack;
  logic [7:0] wdata = 8'h00;
  logic [4:0] gc, g2c;
  logic signed [7:0] gd, g2d;
  logic mu, lo, ro, la, ra, stb, wr, dn, nk, dn2, nk2;
  int fail_count = 0, n_compared = 0;
  localparam int GDB [32] = '{-76, -62, -52, -44, -38, -34, -30, -27,
    -24, -21, -18, -16, -14, -12, -10, -8, -6, -4, -2, 0, 2, 4, 6, 8,
    10, 12, 13, 14, 15, 16, 17, 18};
  wire [3:0] ev = {dn2, dn, stb, wr};
  always #25 clock = ~clock;
  vcs_if u_vcs_if();
  vcs_if u_vcs_if_b();
  vcs_if u_vcs_if_c();
  // Second bus: bench drives clock and data by hand, a foreign address first
  assign u_vcs_if_b.scl = bscl;
  assign u_vcs_if_b.sda_m_oe = bm;
  // Third bus: nobody answers the host
  assign u_vcs_if_c.sda_s_oe = 1'b0;
  vcs_device u_vcs_device (.clock(clock), .nrst(nrst), .bus(u_vcs_if),
    .gain_code(gc), .gain_db(gd), .mute(mu), .left_channel_on(lo),
    .right_channel_on(ro), .left_active(la), .right_active(ra),
    .byte_stb(stb));
  vcs_host #(.HALF(8)) u_vcs_host (.clock(clock), .nrst(nrst),
    .bus(u_vcs_if), .req(req), .wdata(wdata), .last(last), .wready(wr),
    .busy(), .done(dn), .nack(nk));
  vcs_device u_vcs_device_b (.clock(clock), .nrst(nrst),
    .bus(u_vcs_if_b), .gain_code(g2c), .gain_db(g2d), .mute(),
    .left_channel_on(), .right_channel_on(), .left_active(),
    .right_active(), .byte_stb());
  vcs_host #(.HALF(8)) u_vcs_host_c (.clock(clock), .nrst(nrst),
    .bus(u_vcs_if_c), .req(req2), .wdata(wdata), .last(1'b1),
    .wready(), .busy(), .done(dn2), .nack(nk2));
  vcs_monitor #(.HALF(8)) u_vcs_monitor (.clock(clock), .nrst(nrst),
    .scl(u_vcs_if.scl), .sda(u_vcs_if.sda),
    .sda_m_oe(u_vcs_if.sda_m_oe), .sda_s_oe(u_vcs_if.sda_s_oe));
  task chk(input string nm, input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wt(input int i);
    int n;
    for (n = 0; n < 3000 && ev[i] !== 1'b1; n++) @(negedge clock);
    if (n == 3000) begin
      chk("timeout", 8'h01, 8'h00);
      stop_test;
    end
  endtask
  function automatic logic [7:0] byt(input int k);
    return {k[4:0], k[2:0] ^ 3'h3};
  endfunction
  task xfer(input int b, n);
    int k;
    logic [7:0] v;
    wdata = byt(b);
    last = (n == 1);
    req = 1'b1;
    @(negedge clock);
    req = 1'b0;
    for (k = b; k < b + n; k++) begin
      v = byt(k);
      wt(0);
      @(negedge clock);
      wdata = byt(k + 1);
      last = (k + 2 == b + n);
      wt(1);
      @(negedge clock);
      chk("code", {3'h0, gc}, {3'h0, v[7:3]});
      chk("gain", gd, 8'(GDB[v[7:3]]));
      chk("bits", {5'h0, mu, lo, ro}, {5'h0, v[2:0]});
      chk("act", {6'h0, la, ra}, {6'h0, v[1:0] & {2{~v[2]}}});
    end
    wt(2);
    chk("idle", {6'h0, u_vcs_if.scl, u_vcs_if.sda}, 8'h03);
    chk("nack", {7'h0, nk}, 8'h00);
    repeat (4) @(negedge clock);
  endtask
  task hb;
    repeat (8) @(negedge clock);
  endtask
  task bbyte(input logic [7:0] v, input logic e);
    int i;
    for (i = 7; i >= 0; i--) begin
      @(negedge clock);
      bm = ~v[i];
      hb;
      bscl = 1'b1;
      hb;
      bscl = 1'b0;
    end
    @(negedge clock);
    bm = 1'b0;
    hb;
    bscl = 1'b1;
    hb;
    ack = u_vcs_if_b.sda;
    bscl = 1'b0;
    chk("ack", {7'h0, ack}, {7'h0, e});
  endtask
  task bseq(input logic [7:0] a, d, input logic e);
    bm = 1'b1;
    hb;
    bscl = 1'b0;
    bbyte(a, e);
    bbyte(d, e);
    @(negedge clock);
    bm = 1'b1;
    hb;
    bscl = 1'b1;
    hb;
    bm = 1'b0;
    hb;
  endtask
  initial begin
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    xfer(0, 32);
    xfer(9, 1);
    bseq(8'hee, 8'hff, 1'b1);
    chk("foreign", {3'h0, g2c}, 8'h00);
    bseq(vcs_pkg::DEV_ADDR, 8'h9b, 1'b0);
    chk("own", {3'h0, g2c}, 8'h13);
    chk("own_db", g2d, 8'h00);
    req2 = 1'b1;
    @(negedge clock);
    req2 = 1'b0;
    wt(3);
    chk("abort", {7'h0, nk2}, 8'h01);
    chk("abort_idle", {7'h0, u_vcs_if_c.sda}, 8'h01);
    stop_test;
  end
endmodule
